// ==== wakeup_unit_pkg.sv ====
// constants, types and register map of the multi-input wake-up unit
package wakeup_unit_pkg;

    localparam int CHANNELS = 16;
    localparam int IRQ_LINES = 4;
    localparam int SEL_BITS = 2;
    localparam int REG_BITS = 16;
    localparam int ADDR_BITS = 5;
    localparam int DATA_BITS = 32;

    // byte offsets on the register bus
    localparam logic [4:0] OFS_EDGE_SELECT = 5'h00;
    localparam logic [4:0] OFS_CHANNEL_ENABLE = 5'h04;
    localparam logic [4:0] OFS_REQ_SELECT_LOW = 5'h08;
    localparam logic [4:0] OFS_REQ_SELECT_HIGH = 5'h0c;
    localparam logic [4:0] OFS_PENDING_FLAGS = 5'h10;
    localparam logic [4:0] OFS_PENDING_CLEAR = 5'h14;

    // values after reset
    localparam logic [15:0] RST_EDGE_SELECT = 16'h0000;
    localparam logic [15:0] RST_CHANNEL_ENABLE = 16'h0000;
    localparam logic [15:0] RST_REQ_SELECT = 16'h0000;
    localparam logic [15:0] RST_PENDING = 16'h0000;

    // edge select encoding per channel
    localparam logic EDGE_RISING = 1'b0;
    localparam logic EDGE_FALLING = 1'b1;

    // cycles from request edge to waitrequest low
    localparam int BUS_ANSWER_CYCLES = 1;

    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_ANSWER = 1'b1
    } bus_state_e;

    typedef struct packed {
        logic [15:0] edge_select;
        logic [15:0] channel_enable;
        logic [15:0] request_select_low;
        logic [15:0] request_select_high;
    } config_s;

    typedef struct packed {
        logic [15:0] wake_input;
        logic [15:0] level;
    } input_sync_s;

endpackage

// ==== wakeup_unit.sv ====
// sixteen channel edge triggered wake-up and interrupt request unit
// How it works
// - sixteen input channels, pins or peripheral signals, each watched for a trigger
// - a wake-up request output tells the power manager to resume active mode
// - an enabled pending trigger raises an interrupt request toward the controller
// - four request outputs; each channel routes to exactly one of them
// - wake-up only restarts clocks; code runs through the interrupt request
// - edge select bit 0 means rising edge, 1 means falling edge
// - edge select clears on reset, so every channel triggers on rising edges
// - every detected trigger sets its pending bit, enabled or not
// - a pending channel drives wake-up and interrupt only while enabled
// - channel enable bit 1 enables, 0 disables; resets to all disabled
// - reading pending flags returns latched trigger state of every channel
// - edge detection and pending capture run at all times, halt included
// - trigger detection and pending set are synchronous to the system clock, after the input synchronisers
// - request select low holds 2-bit fields for channels 0 to 7; resets zero
// - request select high holds 2-bit fields for channels 8 to 15; resets zero
// - field value 00 to 11 picks request line 0 to 3
// - pending bit 1 means trigger pending, 0 none; reset clears all
// - writing 1 to pending flags sets the bit; 0 leaves it alone
// - write-only pending clear register clears bits written 1; reads return zero
//
// Added by the designer: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
module wakeup_unit #(
    parameter int CHANNELS = wakeup_unit_pkg::CHANNELS
)(
    // clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // avalon-mm slave
    input wire logic [wakeup_unit_pkg::ADDR_BITS-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [wakeup_unit_pkg::DATA_BITS-1:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [wakeup_unit_pkg::DATA_BITS-1:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // wake inputs, pins or peripheral signals
    input wire logic [CHANNELS-1:0] WAKE_INPUT,
    // toward power manager and interrupt controller
    output logic WAKE_REQUEST,
    output logic [wakeup_unit_pkg::IRQ_LINES-1:0] WAKEUP_IRQ
);

    // request lines from pending, enable and per-channel select fields
    function automatic logic [3:0] route_requests(
        input logic [15:0] pend,
        input logic [15:0] ena,
        input logic [31:0] sel
    );
        logic [3:0] res;
        res = 4'h0;
        for (int ch = 0; ch < 16; ch++)
        begin
            if (pend[ch] && ena[ch])
            begin
                res[sel[2*ch +: 2]] = 1'b1;
            end
        end
        return res;
    endfunction

    // byte-enabled merge of a 16-bit register write
    function automatic logic [15:0] merge_bytes(
        input logic [15:0] old,
        input logic [31:0] wdata,
        input logic [3:0] be
    );
        logic [15:0] res;
        res = old;
        if (be[0])
        begin
            res[7:0] = wdata[7:0];
        end
        if (be[1])
        begin
            res[15:8] = wdata[15:8];
        end
        return res;
    endfunction

    // ------------------------------------------------------------------
    // input synchronisers and edge detection
    logic [15:0] sync1_ff;
    logic [15:0] sync2_ff;
    logic [15:0] sync3_ff;
    logic [15:0] level_ff;
    logic [15:0] nxt_level;
    logic [15:0] trigger;
    logic [15:0] wake_in;
    wakeup_unit_pkg::config_s cfg_ff;
    wakeup_unit_pkg::config_s nxt_cfg;
    assign wake_in = 16'(WAKE_INPUT);

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            sync1_ff <= 16'h0000;
            sync2_ff <= 16'h0000;
            sync3_ff <= 16'h0000;
            level_ff <= 16'h0000;
        end
        else
        begin
            sync1_ff <= wake_in;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            level_ff <= nxt_level;
        end
    end

    // only a level that two stages agree on counts as a change
    // edge polarity per channel
    // detection never gated by enables or bus state
    always_comb
    begin
        nxt_level = level_ff;
        trigger = 16'h0000;
        for (int ch = 0; ch < 16; ch++)
        begin
            if (sync2_ff[ch] == sync3_ff[ch])
            begin
                nxt_level[ch] = sync3_ff[ch];
            end
            if (cfg_ff.edge_select[ch] == wakeup_unit_pkg::EDGE_RISING)
            begin
                trigger[ch] = nxt_level[ch] & ~level_ff[ch];
            end
            else
            begin
                trigger[ch] = ~nxt_level[ch] & level_ff[ch];
            end
        end
    end

    // ------------------------------------------------------------------
    // avalon-mm slave: one wait cycle, then a one-cycle answer
    wakeup_unit_pkg::bus_state_e bus_state_ff;
    wakeup_unit_pkg::bus_state_e nxt_bus_state;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic wait_ff;
    logic nxt_wait;
    logic [15:0] pending_ff;
    logic [15:0] nxt_pending;
    logic bus_req;
    logic bus_commit;
    logic wr_pending;
    logic wr_clear;
    logic [15:0] set_mask;
    logic [15:0] clr_mask;

    assign bus_req = AVS_READ || AVS_WRITE;
    assign bus_commit = (bus_state_ff == wakeup_unit_pkg::BUS_ANSWER) && bus_req;

    always_comb
    begin
        nxt_bus_state = bus_state_ff;
        nxt_wait = 1'b1;
        nxt_rdata = rdata_ff;
        case (bus_state_ff)
            wakeup_unit_pkg::BUS_IDLE:
            begin
                if (bus_req)
                begin
                    nxt_bus_state = wakeup_unit_pkg::BUS_ANSWER;
                    nxt_wait = 1'b0;
                    nxt_rdata = 32'h0000_0000;
                    if (AVS_READ)
                    begin
                        case (AVS_ADDRESS)
                            wakeup_unit_pkg::OFS_EDGE_SELECT:
                                nxt_rdata = {16'h0000, cfg_ff.edge_select};
                            wakeup_unit_pkg::OFS_CHANNEL_ENABLE:
                                nxt_rdata = {16'h0000, cfg_ff.channel_enable};
                            wakeup_unit_pkg::OFS_REQ_SELECT_LOW:
                                nxt_rdata = {16'h0000, cfg_ff.request_select_low};
                            wakeup_unit_pkg::OFS_REQ_SELECT_HIGH:
                                nxt_rdata = {16'h0000, cfg_ff.request_select_high};
                            wakeup_unit_pkg::OFS_PENDING_FLAGS:
                                nxt_rdata = {16'h0000, pending_ff};
                            default:
                                nxt_rdata = 32'h0000_0000;
                        endcase
                    end
                end
            end
            wakeup_unit_pkg::BUS_ANSWER:
            begin
                nxt_bus_state = wakeup_unit_pkg::BUS_IDLE;
            end
            default:
            begin
                nxt_bus_state = wakeup_unit_pkg::BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            bus_state_ff <= wakeup_unit_pkg::BUS_IDLE;
            wait_ff <= 1'b1;
            rdata_ff <= 32'h0000_0000;
        end
        else
        begin
            bus_state_ff <= nxt_bus_state;
            wait_ff <= nxt_wait;
            rdata_ff <= nxt_rdata;
        end
    end

    // ------------------------------------------------------------------
    // configuration registers, written at the answer edge only
    always_comb
    begin
        nxt_cfg = cfg_ff;
        if (bus_commit && AVS_WRITE)
        begin
            case (AVS_ADDRESS)
                wakeup_unit_pkg::OFS_EDGE_SELECT:
                    nxt_cfg.edge_select = merge_bytes(cfg_ff.edge_select,
                        AVS_WRITEDATA, AVS_BYTEENABLE);
                wakeup_unit_pkg::OFS_CHANNEL_ENABLE:
                    nxt_cfg.channel_enable = merge_bytes(cfg_ff.channel_enable,
                        AVS_WRITEDATA, AVS_BYTEENABLE);
                wakeup_unit_pkg::OFS_REQ_SELECT_LOW:
                    nxt_cfg.request_select_low = merge_bytes(cfg_ff.request_select_low,
                        AVS_WRITEDATA, AVS_BYTEENABLE);
                wakeup_unit_pkg::OFS_REQ_SELECT_HIGH:
                    nxt_cfg.request_select_high = merge_bytes(cfg_ff.request_select_high,
                        AVS_WRITEDATA, AVS_BYTEENABLE);
                default:
                    nxt_cfg = cfg_ff;
            endcase
        end
    end

    // low select resets to line 0
    // high select resets to line 0
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            cfg_ff.edge_select <= wakeup_unit_pkg::RST_EDGE_SELECT;
            cfg_ff.channel_enable <= wakeup_unit_pkg::RST_CHANNEL_ENABLE;
            cfg_ff.request_select_low <= wakeup_unit_pkg::RST_REQ_SELECT;
            cfg_ff.request_select_high <= wakeup_unit_pkg::RST_REQ_SELECT;
        end
        else
        begin
            cfg_ff <= nxt_cfg;
        end
    end

    // ------------------------------------------------------------------
    // pending flags: hardware set and software set win over clear
    assign wr_pending = bus_commit && AVS_WRITE
        && (AVS_ADDRESS == wakeup_unit_pkg::OFS_PENDING_FLAGS);
    assign wr_clear = bus_commit && AVS_WRITE
        && (AVS_ADDRESS == wakeup_unit_pkg::OFS_PENDING_CLEAR);

    always_comb
    begin
        set_mask = 16'h0000;
        clr_mask = 16'h0000;
        // write of one sets, zero ignored
        if (wr_pending)
        begin
            set_mask = merge_bytes(16'h0000, AVS_WRITEDATA, AVS_BYTEENABLE);
        end
        if (wr_clear)
        begin
            clr_mask = merge_bytes(16'h0000, AVS_WRITEDATA, AVS_BYTEENABLE);
        end
        nxt_pending = (pending_ff & ~clr_mask) | set_mask | trigger;
    end

    // set path fed from the synchronised edge, not from bus timing
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            pending_ff <= wakeup_unit_pkg::RST_PENDING;
        end
        else
        begin
            pending_ff <= nxt_pending;
        end
    end

    // ------------------------------------------------------------------
    // request outputs; wake-up only asks for clocks, the irq starts code
    logic wake_ff;
    logic nxt_wake;
    logic [3:0] irq_ff;
    logic [3:0] nxt_irq;
    logic [31:0] sel_all;

    assign sel_all = {cfg_ff.request_select_high, cfg_ff.request_select_low};

    always_comb
    begin
        nxt_wake = |(pending_ff & cfg_ff.channel_enable);
        nxt_irq = route_requests(pending_ff, cfg_ff.channel_enable, sel_all);
    end

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            wake_ff <= 1'b0;
            irq_ff <= 4'h0;
        end
        else
        begin
            wake_ff <= nxt_wake;
            irq_ff <= nxt_irq;
        end
    end

    assign AVS_READDATA = rdata_ff;
    assign AVS_WAITREQUEST = wait_ff;
    assign WAKE_REQUEST = wake_ff;
    assign WAKEUP_IRQ = irq_ff;

    // ------------------------------------------------------------------
    // checks
    sequence s_bus_request;
        bus_req && (bus_state_ff == wakeup_unit_pkg::BUS_IDLE);
    endsequence

    sequence s_bus_answer;
        !wait_ff ##1 wait_ff;
    endsequence

    a_bus_answer_time: assert property (@(posedge CLK) disable iff (!RESET_N)
        s_bus_request |=> s_bus_answer)
        else $error("bus answer not one cycle after request");

    a_pend_read_value: assert property (@(posedge CLK) disable iff (!RESET_N)
        (AVS_READ && bus_state_ff == wakeup_unit_pkg::BUS_IDLE
            && AVS_ADDRESS == wakeup_unit_pkg::OFS_PENDING_FLAGS)
        |=> AVS_READDATA == {16'h0000, $past(pending_ff)})
        else $error("pending read returned wrong value");

    a_edge_sets_pend: assert property (@(posedge CLK) disable iff (!RESET_N)
        (trigger != 16'h0000) |=> ((pending_ff & $past(trigger)) == $past(trigger)))
        else $error("trigger did not set pending bit");

    a_clear_removes_pend: assert property (@(posedge CLK) disable iff (!RESET_N)
        (wr_clear && trigger == 16'h0000)
        |=> ((pending_ff & $past(clr_mask)) == 16'h0000))
        else $error("pending clear did not clear");

    a_set_never_clears: assert property (@(posedge CLK) disable iff (!RESET_N)
        (wr_pending) |=> ((pending_ff & $past(pending_ff)) == $past(pending_ff)))
        else $error("pending write cleared a bit");

    a_rising_default: assert property (@(posedge CLK) disable iff (!RESET_N)
        (cfg_ff.edge_select[0] == wakeup_unit_pkg::EDGE_RISING
            && sync3_ff[0] && sync2_ff[0] && !level_ff[0])
        |-> trigger[0])
        else $error("rising edge not detected on channel 0");

    a_wake_gate: assert property (@(posedge CLK) disable iff (!RESET_N)
        ((pending_ff & cfg_ff.channel_enable) == 16'h0000) |=> !WAKE_REQUEST)
        else $error("wake request without enabled pending channel");

    a_irq_routing: assert property (@(posedge CLK) disable iff (!RESET_N)
        1'b1 |=> WAKEUP_IRQ == route_requests($past(pending_ff),
            $past(cfg_ff.channel_enable), $past(sel_all)))
        else $error("interrupt line does not match routing");

    a_irq_disabled: assert property (@(posedge CLK) disable iff (!RESET_N)
        (cfg_ff.channel_enable == 16'h0000) [*2] |-> WAKEUP_IRQ == 4'h0)
        else $error("interrupt with all channels disabled");

endmodule

// ==== pmu_icu_model.sv ====
// behavioural power manager and interrupt controller facing the wake-up unit
`timescale 1ns/1ps
module pmu_icu_model (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // requests from the wake-up unit
    input wire logic wake_request,
    input wire logic [3:0] wakeup_irq,
    // activity seen by the far side
    output logic [7:0] wake_cnt,
    output logic [7:0] isr_cnt
);
    logic wake_d_ff;
    logic irq_d_ff;
    // wake only resumes clocks; an irq rise starts a handler
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wake_d_ff <= 1'b0;
            irq_d_ff <= 1'b0;
            wake_cnt <= 8'h00;
            isr_cnt <= 8'h00;
        end
        else
        begin
            wake_d_ff <= wake_request;
            irq_d_ff <= |wakeup_irq;
            if (wake_request && !wake_d_ff)
            begin
                wake_cnt <= wake_cnt + 8'h01;
            end
            if ((|wakeup_irq) && !irq_d_ff)
            begin
                isr_cnt <= isr_cnt + 8'h01;
            end
        end
    end
endmodule

// ==== tb.sv ====
// self-checking testbench of the wake-up unit over its avalon-mm port
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [4:0] address = 5'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] be = 4'hf;
    logic [31:0] rdata;
    logic waitreq;
    logic [15:0] wake_in = 16'h0000;
    logic wake_req;
    logic [3:0] irq;
    logic [7:0] wake_cnt;
    logic [7:0] isr_cnt;
    logic [31:0] got;
    int error_cnt = 0;
    int samples_checked = 0;
    int cycles = 0;
    // routing: low fields 0,1,2,3 repeated; high fields 3,2,1,0 repeated
    localparam logic [15:0] SEL_LO = 16'he4e4;
    localparam logic [15:0] SEL_HI = 16'h1b1b;
    localparam logic [15:0] EDGES = 16'haaaa;

    always #10 clk = ~clk;

    wakeup_unit i_dut (
        .CLK(clk), .RESET_N(reset_n), .AVS_ADDRESS(address), .AVS_READ(rd),
        .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be),
        .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq), .WAKE_INPUT(wake_in),
        .WAKE_REQUEST(wake_req), .WAKEUP_IRQ(irq)
    );

    pmu_icu_model i_far (
        .clk(clk), .reset_n(reset_n), .wake_request(wake_req), .wakeup_irq(irq),
        .wake_cnt(wake_cnt), .isr_cnt(isr_cnt)
    );

    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // the limit sits far above the several hundred cycles the tests need
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            error_cnt++;
            end_of_test();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        samples_checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // request held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        address <= a;
        wdata <= {16'h0000, d};
        rd <= !w;
        wr <= w;
        do @(posedge clk); while (waitreq !== 1'b0);
        got = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp, input string what);
        bus(1'b0, a, 16'h0000);
        check(got, {16'h0000, exp}, what);
    endtask

    function automatic logic [3:0] line_mask(input int c);
        logic [15:0] s;
        s = (c < 8) ? SEL_LO : SEL_HI;
        return 4'h1 << s[2 * (c % 8) +: 2];
    endfunction

    initial
    begin
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        // every register and the unmapped slot read zero after reset
        for (int a = 0; a <= 24; a += 4)
            rd_chk(a[4:0], 16'h0000, "reset value");
        $display("test reset values done");

        bus(1'b1, 5'h18, 16'hffff);
        rd_chk(5'h18, 16'h0000, "unmapped");
        bus(1'b1, wakeup_unit_pkg::OFS_REQ_SELECT_LOW, 16'h5a3c);
        rd_chk(wakeup_unit_pkg::OFS_REQ_SELECT_LOW, 16'h5a3c, "select low rw");
        be <= 4'h2;
        bus(1'b1, wakeup_unit_pkg::OFS_REQ_SELECT_HIGH, 16'hc3a5);
        be <= 4'hf;
        rd_chk(wakeup_unit_pkg::OFS_REQ_SELECT_HIGH, 16'hc300, "byte enable");
        bus(1'b1, wakeup_unit_pkg::OFS_PENDING_FLAGS, 16'h8001);
        rd_chk(wakeup_unit_pkg::OFS_PENDING_FLAGS, 16'h8001, "pending set");
        bus(1'b1, wakeup_unit_pkg::OFS_PENDING_FLAGS, 16'h0000);
        rd_chk(wakeup_unit_pkg::OFS_PENDING_FLAGS, 16'h8001, "pending keep");
        bus(1'b1, wakeup_unit_pkg::OFS_PENDING_CLEAR, 16'h0001);
        rd_chk(wakeup_unit_pkg::OFS_PENDING_FLAGS, 16'h8000, "pending clear");
        rd_chk(wakeup_unit_pkg::OFS_PENDING_CLEAR, 16'h0000, "clear reads");
        check({31'h0, wake_req}, 32'h0, "wake while disabled");
        $display("test register access done");

        // setup order: disable, edges, clear pending, route, then enable per channel
        bus(1'b1, wakeup_unit_pkg::OFS_CHANNEL_ENABLE, 16'h0000);
        bus(1'b1, wakeup_unit_pkg::OFS_EDGE_SELECT, EDGES);
        rd_chk(wakeup_unit_pkg::OFS_EDGE_SELECT, EDGES, "edge rw");
        bus(1'b1, wakeup_unit_pkg::OFS_PENDING_CLEAR, 16'hffff);
        bus(1'b1, wakeup_unit_pkg::OFS_REQ_SELECT_LOW, SEL_LO);
        bus(1'b1, wakeup_unit_pkg::OFS_REQ_SELECT_HIGH, SEL_HI);
        for (int c = 0; c < 16; c++)
        begin
            // odd channels fall-triggered: a rise must leave pending clear
            if (EDGES[c])
            begin
                wake_in[c] <= 1'b1;
                repeat (8) @(posedge clk);
                rd_chk(wakeup_unit_pkg::OFS_PENDING_FLAGS, 16'h0000, "rise ignored");
            end
            wake_in[c] <= !EDGES[c];
            repeat (8) @(posedge clk);
            rd_chk(wakeup_unit_pkg::OFS_PENDING_FLAGS, 16'h1 << c, "pend");
            check({28'h0, irq}, 32'h0, "irq disabled");
            bus(1'b1, wakeup_unit_pkg::OFS_CHANNEL_ENABLE, 16'h1 << c);
            repeat (3) @(posedge clk);
            check({31'h0, wake_req}, 32'h1, "wake on");
            check({28'h0, irq}, {28'h0, line_mask(c)}, "irq line");
            check({24'h0, wake_cnt}, c + 1, "far side wake");
            check({24'h0, isr_cnt}, c + 1, "far side irq");
            bus(1'b1, wakeup_unit_pkg::OFS_PENDING_CLEAR, 16'h1 << c);
            repeat (3) @(posedge clk);
            check({27'h0, wake_req, irq}, 32'h0, "cleared");
            bus(1'b1, wakeup_unit_pkg::OFS_CHANNEL_ENABLE, 16'h0000);
            wake_in[c] <= 1'b0;
            repeat (8) @(posedge clk);
            rd_chk(wakeup_unit_pkg::OFS_PENDING_FLAGS, 16'h0000, "opposite edge");
        end
        $display("test channel routing done");

        // four channels on line 3 at once, then a reset in mid-run restores defaults
        bus(1'b1, wakeup_unit_pkg::OFS_EDGE_SELECT, 16'hffff);
        bus(1'b1, wakeup_unit_pkg::OFS_REQ_SELECT_LOW, 16'hffff);
        bus(1'b1, wakeup_unit_pkg::OFS_REQ_SELECT_HIGH, 16'hffff);
        bus(1'b1, wakeup_unit_pkg::OFS_PENDING_FLAGS, 16'h00ff);
        bus(1'b1, wakeup_unit_pkg::OFS_CHANNEL_ENABLE, 16'h0f0f);
        repeat (3) @(posedge clk);
        check({27'h0, wake_req, irq}, 32'h18, "before reset");
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        check({27'h0, wake_req, irq}, 32'h0, "in reset");
        reset_n <= 1'b1;
        for (int a = 0; a <= 16; a += 4)
            rd_chk(a[4:0], 16'h0000, "second reset");
        $display("test second reset done");
        end_of_test();
    end
endmodule
